//--- include/ipl_pkg.sv
/*
  package for the instruction prefix latch: register map, field layout, reset values, carrier types.
  assumes a single core clock and a plain strobe register port.
*/
package ipl_pkg;

  localparam int unsigned IPL_ADDR_W      = 8;
  localparam int unsigned IPL_DATA_W      = 16;
  localparam int unsigned IPL_IDX_W       = 3;
  // prefix module number; the low three address bits carry the alias index
  localparam logic [4:0]  IPL_MODULE      = 5'h0b;
  localparam int unsigned IPL_MOD_LSB     = 3;
  localparam logic [15:0] IPL_PREFIX_RST  = 16'h0000;
  localparam logic [2:0]  IPL_INDEX_RST   = 3'h0;
  localparam int unsigned IPL_HOLD_CYCLES = 1;
  localparam int unsigned IPL_PDATA_W     = 8;
  localparam int unsigned IPL_SRC_BIT     = 0;
  localparam int unsigned IPL_DST_LSB     = 1;

  typedef struct packed {
    logic [IPL_ADDR_W-1:0] addr;
    logic [IPL_DATA_W-1:0] wdata;
    logic                  wr;
    logic                  rd;
  } ipl_bus_req_t;

  typedef struct packed {
    logic                   valid;
    logic [IPL_PDATA_W-1:0] high_byte;
    logic                   src_bank;
    logic [1:0]             dst_bank;
  } ipl_prefix_t;

endpackage : ipl_pkg

//--- verilog/ipl_latch.sv
/*
  instruction prefix latch: one 16-bit register reached through eight aliases; it holds a write for
  one execution cycle and hands its low byte and the alias bank selects to the next instruction.
  assumes every clock edge is one execution cycle and the decoder samples prefix_out each cycle.
*/
// The address-and-strobe port was left to the implementer.
// Functional notes
// - prefix register clears to zero on every reset.
// - a written value stands one execution cycle, then reverts to zero.
// - held low byte is supplied as high data byte to next instruction.
// - all 16 bits stored; only bits 7:0 prefix the next instruction.
// - all eight aliases read and write the same 16-bit register.
// - written alias index bit 0 selects source bank 0h-Fh or 10h-1Fh.
// - indices 0-1 give dest 0h-7h, 2-3 give 8h-Fh, 4-5 give 10h-17h, 6-7 give 18h-1Fh.
// - reads and writes allowed at all times without restriction; here a write or read is dropped while sys_rst_in is high.
// - captured index returns to zero after the prefixed cycle.
module ipl_latch
  import ipl_pkg::*;
(
  // clock and reset
  input  wire logic                  ref_clk_in,
  input  wire logic                  sys_rst_in,
  // register port
  input  wire ipl_bus_req_t          bus_in,
  output logic [IPL_DATA_W-1:0]      rdata_out,
  // towards the decoder
  output ipl_prefix_t                prefix_out
);

  function automatic logic hits(input logic [IPL_ADDR_W-1:0] a);
    hits = (a[IPL_ADDR_W-1:IPL_MOD_LSB] == IPL_MODULE);
  endfunction : hits

  // lowest register number that each alias opens to the next destination
  function automatic logic [4:0] dst_base(input logic [IPL_IDX_W-1:0] idx);
    case (idx)
      3'h0, 3'h1: dst_base = 5'h00;
      3'h2, 3'h3: dst_base = 5'h08;
      3'h4, 3'h5: dst_base = 5'h10;
      default:    dst_base = 5'h18;
    endcase
  endfunction : dst_base

  // lowest register number that each alias opens to the next source
  function automatic logic [4:0] src_base(input logic [IPL_IDX_W-1:0] idx);
    case (idx)
      3'h1, 3'h3, 3'h5, 3'h7: src_base = 5'h10;
      default:                src_base = 5'h00;
    endcase
  endfunction : src_base

  ////////////////////////////////////////////////////////////////////////////
  // age counter wide enough to count up to the hold time
  localparam int unsigned AGE_W = $clog2(IPL_HOLD_CYCLES + 2);

  logic [IPL_DATA_W-1:0] value_reg, value_next;
  logic [IPL_IDX_W-1:0]  index_reg, index_next;
  logic                  valid_reg, valid_next;
  logic [AGE_W-1:0]      age_reg, age_next;
  logic [IPL_DATA_W-1:0] rdata_reg, rdata_next;
  logic                  wr_hit;
  logic                  rd_hit;

  // any alias inside the module window is the same register
  assign wr_hit = bus_in.wr && hits(bus_in.addr);
  assign rd_hit = bus_in.rd && hits(bus_in.addr);

  ////////////////////////////////////////////////////////////////////////////
  // prefix group: a write arms the prefix, which then stands for the hold time only
  always_comb begin
    value_next = IPL_PREFIX_RST;
    index_next = IPL_INDEX_RST;
    valid_next = 1'b0;
    age_next   = '0;
    if (wr_hit) begin
      value_next = bus_in.wdata;
      index_next = bus_in.addr[IPL_IDX_W-1:0];
      valid_next = 1'b1;
      age_next   = AGE_W'(1);
    end else if (valid_reg && (age_reg < AGE_W'(IPL_HOLD_CYCLES))) begin
      value_next = value_reg;
      index_next = index_reg;
      valid_next = 1'b1;
      age_next   = age_reg + AGE_W'(1);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      value_reg <= IPL_PREFIX_RST;
      index_reg <= IPL_INDEX_RST;
      valid_reg <= 1'b0;
      age_reg   <= '0;
    end else begin
      value_reg <= value_next;
      index_reg <= index_next;
      valid_reg <= valid_next;
      age_reg   <= age_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read group: the word answers one cycle after the strobe and is zero otherwise
  always_comb begin
    rdata_next = '0;
    if (rd_hit) begin
      rdata_next = value_reg;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign rdata_out            = rdata_reg;
  assign prefix_out.valid     = valid_reg;
  assign prefix_out.high_byte = value_reg[IPL_PDATA_W-1:0];
  assign prefix_out.src_bank  = index_reg[IPL_SRC_BIT];
  assign prefix_out.dst_bank  = index_reg[IPL_DST_LSB+1:IPL_DST_LSB];

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);

  property p_reset_clear;
    sys_rst_in |=> (rdata_out == '0) && (prefix_out.high_byte == '0);
  endproperty
  a_reset_clear: assert property (disable iff (1'b0) p_reset_clear) else $error("prefix not cleared");

  property p_one_cycle;
    (bus_in.wr && hits(bus_in.addr)) ##1 !(bus_in.wr && hits(bus_in.addr)) |=> !prefix_out.valid &&
      prefix_out.high_byte == '0 && prefix_out.dst_bank == '0 && !prefix_out.src_bank;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("prefix held too long");

  property p_byte;
    bus_in.wr && hits(bus_in.addr) |=> prefix_out.valid && prefix_out.high_byte == $past(bus_in.wdata[7:0]);
  endproperty
  a_byte: assert property (p_byte) else $error("prefix byte wrong");

  property p_full_word;
    bus_in.wr && hits(bus_in.addr) ##1 bus_in.rd && hits(bus_in.addr) |=> rdata_out == $past(bus_in.wdata, 2);
  endproperty
  a_full_word: assert property (p_full_word) else $error("stored word wrong");

  // a word written through one alias reads back whole through any other
  property p_alias;
    wr_hit ##1 rd_hit && (bus_in.addr[IPL_IDX_W-1:0] != $past(bus_in.addr[IPL_IDX_W-1:0]))
      |=> rdata_out == $past(bus_in.wdata, 2);
  endproperty
  a_alias: assert property (p_alias) else $error("alias read wrong");

  property p_src;
    bus_in.wr && hits(bus_in.addr) |=> prefix_out.src_bank == $past(bus_in.addr[0]);
  endproperty
  a_src: assert property (p_src) else $error("source bank wrong");

  property p_dst;
    bus_in.wr && hits(bus_in.addr) |=> prefix_out.dst_bank == $past(bus_in.addr[2:1]);
  endproperty
  a_dst: assert property (p_dst) else $error("destination bank wrong");

  property p_idle;
    !(bus_in.wr && hits(bus_in.addr)) |=> prefix_out.dst_bank == '0 && !prefix_out.valid;
  endproperty
  a_idle: assert property (p_idle) else $error("index not reverted");

  // reset and expiry
  property p_reset_banks;
    sys_rst_in |=> !prefix_out.valid && !prefix_out.src_bank && (prefix_out.dst_bank == '0);
  endproperty
  a_reset_banks: assert property (disable iff (1'b0) p_reset_banks) else $error("prefix selects not cleared");

  property p_idle_byte;
    !wr_hit |=> (prefix_out.high_byte == '0) && !prefix_out.src_bank;
  endproperty
  a_idle_byte: assert property (p_idle_byte) else $error("prefix byte not reverted");

  property p_valid_cause;
    prefix_out.valid |-> $past(wr_hit);
  endproperty
  a_valid_cause: assert property (p_valid_cause) else $error("prefix without a write");

  property p_read_cleared;
    rd_hit && !$past(wr_hit) |=> rdata_out == '0;
  endproperty
  a_read_cleared: assert property (p_read_cleared) else $error("expired prefix read not zero");

  // module window decode
  property p_read_quiet;
    !rd_hit |=> rdata_out == '0;
  endproperty
  a_read_quiet: assert property (p_read_quiet) else $error("read data outside a read");

  property p_refused_write;
    bus_in.wr && !hits(bus_in.addr) |=> !prefix_out.valid && (prefix_out.high_byte == '0);
  endproperty
  a_refused_write: assert property (p_refused_write) else $error("foreign write armed prefix");

  // register ranges opened by each alias
  property p_dst_range;
    wr_hit |=> {prefix_out.dst_bank, 3'h0} == dst_base($past(bus_in.addr[IPL_IDX_W-1:0]));
  endproperty
  a_dst_range: assert property (p_dst_range) else $error("destination range wrong");

  property p_src_range;
    wr_hit |=> {prefix_out.src_bank, 4'h0} == src_base($past(bus_in.addr[IPL_IDX_W-1:0]));
  endproperty
  a_src_range: assert property (p_src_range) else $error("source range wrong");

  c_write: cover property (bus_in.wr && hits(bus_in.addr) && bus_in.addr[2:0] == 3'h7);
  c_back: cover property ((bus_in.wr && hits(bus_in.addr)) [*2]);
  c_read_held: cover property (bus_in.wr && hits(bus_in.addr) ##1 bus_in.rd && hits(bus_in.addr));
  c_reset_write: cover property (disable iff (1'b0) sys_rst_in && wr_hit);
  c_alias_cross: cover property (wr_hit ##1 rd_hit && (bus_in.addr[IPL_IDX_W-1:0] != $past(bus_in.addr[IPL_IDX_W-1:0])));

endmodule : ipl_latch

//--- bench/ipl_latch_bench.sv
/*
  self-checking bench for ipl_latch: alias writes, reads, self-clear, unmapped access, reset.
  assumes one-cycle registered answers on rdata_out and prefix_out.
*/
module ipl_latch_bench
  import ipl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic         ref_clk_in = 1'b0;
  logic         sys_rst_in = 1'b1;
  ipl_bus_req_t bus_in     = '0;
  logic [15:0]  rdata_out;
  ipl_prefix_t  prefix_out;
  int           miscompares = 0;
  int           tests_run   = 0;
  ipl_latch dut_u (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .bus_in(bus_in),
                   .rdata_out(rdata_out), .prefix_out(prefix_out));
  always #4 ref_clk_in = ~ref_clk_in;
  ////////////////////////////////////////
  task automatic chk_pfx(input ipl_prefix_t exp);
    tests_run++;
    if (prefix_out !== exp) begin
      miscompares++;
      $display("FAIL t=%0t prefix got %h exp %h", $time, prefix_out, exp);
    end
  endtask : chk_pfx
  task automatic chk_word(input logic [15:0] exp);
    tests_run++;
    if (rdata_out !== exp) begin
      miscompares++;
      $display("FAIL t=%0t rdata got %h exp %h", $time, rdata_out, exp);
    end
  endtask : chk_word
  // one bus cycle, then let the edge's updates settle
  task automatic step(input logic [7:0] a, input logic [15:0] d, input logic w, input logic r);
    @(posedge ref_clk_in);
    bus_in <= '{addr: a, wdata: d, wr: w, rd: r};
    #1;
  endtask : step
  function automatic ipl_prefix_t pfx_of(input logic [2:0] n, input logic [15:0] d);
    return '{valid: 1'b1, high_byte: d[7:0], src_bank: n[0], dst_bank: n[2:1]};
  endfunction : pfx_of
  ////////////////////////////////////////
  task automatic t_alias;
    logic [15:0] d;
    for (int n = 0; n < 8; n++) begin
      d = {8'hc0 | 8'(n), 8'h5a ^ 8'(n)};
      step({5'h0b, 3'(n)}, d, 1'b1, 1'b0);
      step({5'h0b, 3'(n) ^ 3'h3}, 16'h0000, 1'b0, 1'b1);
      chk_pfx(pfx_of(3'(n), d));
      step(8'h00, 16'h0000, 1'b0, 1'b0);
      chk_word(d);
      chk_pfx('0);
    end
    $display("test alias done");
  endtask : t_alias
  task automatic t_order;
    step(8'h59, 16'hbeef, 1'b1, 1'b0);
    step(8'h5e, 16'h0f21, 1'b1, 1'b0);
    chk_pfx(pfx_of(3'h1, 16'hbeef));
    step(8'h60, 16'hffff, 1'b1, 1'b0);
    chk_pfx(pfx_of(3'h6, 16'h0f21));
    step(8'h60, 16'h0000, 1'b0, 1'b1);
    chk_pfx('0);
    step(8'h58, 16'h0000, 1'b0, 1'b1);
    chk_word(16'h0000);
    step(8'h00, 16'h0000, 1'b0, 1'b0);
    chk_word(16'h0000);
    step(8'h5b, 16'h1234, 1'b1, 1'b0);
    sys_rst_in <= 1'b1;
    step(8'h00, 16'h0000, 1'b0, 1'b0);
    chk_pfx('0);
    sys_rst_in <= 1'b0;
    step(8'h5b, 16'h0000, 1'b0, 1'b1);
    step(8'h00, 16'h0000, 1'b0, 1'b0);
    chk_word(16'h0000);
    $display("test order done");
  endtask : t_order
  ////////////////////////////////////////
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report
  initial begin
    repeat (10) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    step(8'h00, 16'h0000, 1'b0, 1'b0);
    chk_pfx('0);
    chk_word(16'h0000);
    t_alias();
    t_order();
    final_report();
  end
  // tests need well under 100 cycles
  initial begin
    #20000;
    miscompares++;
    final_report();
  end
endmodule : ipl_latch_bench
